// ---- sic_pkg.sv ----
package sic_pkg;

  // Integration counter
  localparam int CNT_W = 12;
  localparam int REC_LONG_CYC = 4096;
  localparam int REC_SHORT_CYC = 32;
  localparam logic [CNT_W-1:0] REC_LONG_LAST = CNT_W'(REC_LONG_CYC - 1);
  localparam logic [CNT_W-1:0] REC_SHORT_LAST = CNT_W'(REC_SHORT_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_RST = 12'h000;

  // Interrupt sources, index 0 has the highest priority
  localparam int NIRQ = 8;
  localparam int IDX_W = 3;

  // Sequencer states
  typedef enum logic [4:0] {
    SIC_RUN   = 5'h01,
    SIC_WAIT  = 5'h02,
    SIC_STOP  = 5'h04,
    SIC_RECOV = 5'h08,
    SIC_INT   = 5'h10
  } sic_state_t;

  // Opcodes presented by the core at an instruction boundary
  typedef struct packed {
    logic wait_op;
    logic stop_op;
    logic swi_op;
    logic rti_op;
  } sic_op_t;

  // Clock gates driven out of the block
  typedef struct packed {
    logic cpu;
    logic per;
    logic xtal;
    logic base;
  } sic_clk_en_t;

  localparam sic_clk_en_t CLK_EN_RST = 4'hF;

  // Arbitration result handed to the core
  typedef struct packed {
    logic             software_interrupt_instr;
    logic [IDX_W-1:0] idx;
  } sic_vec_t;

  localparam sic_vec_t VEC_RST = 4'h0;

endpackage

// ---- sic_counter.sv ----
`timescale 1ns/10ps
`default_nettype none
module sic_counter (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_clr,
  output logic [sic_pkg::CNT_W-1:0]      o_cnt,
  output logic                           o_ovf
);

  logic [sic_pkg::CNT_W-1:0] cnt_q;
  logic                      ovf_q;

  // Internal reset or i_clr clears, otherwise free running; pin reset never reaches here
  always_ff @(posedge i_clk) begin // R1 R5 R6
    if (!i_rst_n) begin
      cnt_q <= sic_pkg::CNT_RST;
    end else if (i_clr) begin
      cnt_q <= sic_pkg::CNT_RST; // R3
    end else begin
      cnt_q <= cnt_q + 12'h001;
    end
  end

  // One pulse each time the counter wraps
  always_ff @(posedge i_clk) begin // R2
    if (!i_rst_n) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= !i_clr && (&cnt_q);
    end
  end

  assign o_cnt = cnt_q;
  assign o_ovf = ovf_q;

endmodule
`default_nettype wire

// ---- sic_top.sv ----
// What this block does
// R1: Twelve-bit integration counter advances once per crystal clock cycle.
// R2: Counter overflow pulse clocks the watchdog, acting as its prescaler.
// R3: Stop opcode clears counter, held clear until recovery, then times recovery.
// R4: On stop wake sample short recovery bit: 32 cycles if set, else 4096.
// R5: External pin reset leaves the counter value untouched.
// R6: Counter runs freely once any reset has ended.
// R7: Latch requests, arbitrate at interrupt start, hold a constant vector result.
// R8: A latched interrupt is not pre-empted until serviced or mask cleared.
// R9: Take hardware interrupts only at instruction end, mask clear, source enabled.
// R10: Highest priority first; requests pending after return are taken at once.
// R11: Entry stacks registers except index high and sets mask; return restores.
// R12: Software interrupt ignores mask and stacks PC; hardware stacks PC minus one.
// R13: Every reset outranks interrupts and bypasses arbitration; a pin reset in stop or recovery still leaves a hardware request latched.
// R14: Break output forces a fetch from the software interrupt vector.
// R15: In break, flag clearing blocked unless enable set; cleared flags stay cleared.
// R16: Two-step flag clears are protected in break; second step after break works.
// R17: Wait or stop opcode clears the mask and stops the processor clock.
// R18: Wait stops processor clock only; enabled interrupt wakes, stacking next cycle.
// R19: Reset or break also ends wait; break in wait sets the wait flag.
// R20: With watchdog disable low the watchdog stays enabled through wait.
// R21: Stop gates base and crystal clocks; stacking waits for recovery delay.
// R22: Break module inactive in stop; stop leaves its registers unchanged.
// R23: Writing zero clears the break wait flag; any reset clears it too.
// R24: Stop opcode with stop disabled raises an illegal opcode reset.
// R25: Recovery count reached re-enables processor and peripheral clocks first.
`timescale 1ns/10ps
`default_nettype none
module sic_top (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_pin_rst,
  input  wire logic                       i_stop_en,
  input  wire logic                       i_short_stop_recovery,
  input  wire logic                       i_watchdog_disable,
  input  wire logic                       i_break_clear_flag_enable,
  input  wire logic                       i_break,
  input  wire logic                       i_insn_done,
  input  wire sic_pkg::sic_op_t           i_op,
  input  wire logic                       i_int_mask,
  input  wire logic                       i_vec_done,
  input  wire logic [sic_pkg::NIRQ-1:0]   i_irq_req,
  input  wire logic [sic_pkg::NIRQ-1:0]   i_irq_en,
  input  wire logic                       i_bw_wr,
  input  wire logic                       i_bw_wdata,
  output logic                            o_int_start,
  output logic                            o_stack_pc,
  output logic                            o_set_mask,
  output logic                            o_clr_mask,
  output logic                            o_restore,
  output logic                            o_ilop_rst,
  output sic_pkg::sic_vec_t               o_vec,
  output logic                            o_vec_vld,
  output sic_pkg::sic_clk_en_t            o_clk_en,
  output logic                            o_brk_mod_en,
  output logic                            o_in_break,
  output logic                            o_flag_clr_allow,
  output logic                            o_break_wait_flag,
  output logic                            o_wdog_en,
  output logic                            o_wdog_tick,
  output logic                            o_recov_busy
);

  // Lowest index of a pending request
  function automatic logic [sic_pkg::IDX_W-1:0] prio(input logic [sic_pkg::NIRQ-1:0] p);
    logic [sic_pkg::IDX_W-1:0] r;
    r = '0;
    for (int k = sic_pkg::NIRQ - 1; k >= 0; k--) begin
      if (p[k]) begin
        r = k[sic_pkg::IDX_W-1:0];
      end
    end
    return r;
  endfunction

  // Gate pattern for each state
  function automatic sic_pkg::sic_clk_en_t gates(input sic_pkg::sic_state_t s);
    sic_pkg::sic_clk_en_t g;
    g = sic_pkg::CLK_EN_RST;
    unique case (s)
      sic_pkg::SIC_WAIT:  g = 4'h7;
      sic_pkg::SIC_STOP:  g = 4'h0;
      sic_pkg::SIC_RECOV: g = 4'h2;
      default:            g = sic_pkg::CLK_EN_RST;
    endcase
    return g;
  endfunction

  sic_pkg::sic_state_t         state_q;
  sic_pkg::sic_state_t         state_d;
  logic [sic_pkg::CNT_W-1:0]   cnt;
  logic                        cnt_ovf;
  logic                        cnt_clr;
  logic                        short_stop_recovery_q;
  logic                        rst_wake_q;
  logic                        mask_q;
  logic                        lat_vld_q;
  sic_pkg::sic_vec_t           vec_q;
  logic                        in_break_q;
  logic                        bw_q;
  logic [sic_pkg::NIRQ-1:0]    hw_pend;
  logic                        hw_any;
  logic                        hw_ok;
  logic                        brk_enter;
  logic                        brk_exit;
  logic                        swi_enter;
  logic                        rec_done;
  logic                        enter_int;
  logic                        ilop;
  logic [sic_pkg::CNT_W-1:0]   rec_last;

  logic                        int_start_q;
  logic                        stack_pc_q;
  logic                        set_mask_q;
  logic                        clr_mask_q;
  logic                        restore_q;
  logic                        ilop_q;
  sic_pkg::sic_clk_en_t        clk_en_q;
  logic                        brk_mod_en_q;
  logic                        allow_q;
  logic                        wdog_en_q;
  logic                        wdog_tick_q;
  logic                        recov_q;

  sic_counter u_counter (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_clr   (cnt_clr),
    .o_cnt   (cnt),
    .o_ovf   (cnt_ovf)
  );

  assign hw_pend   = i_irq_req & i_irq_en;
  assign hw_any    = |hw_pend;
  assign hw_ok     = hw_any && !i_int_mask; // R9
  assign rec_last  = short_stop_recovery_q ? sic_pkg::REC_SHORT_LAST : sic_pkg::REC_LONG_LAST; // R4
  assign rec_done  = (state_q == sic_pkg::SIC_RECOV) && (cnt == rec_last);
  assign ilop      = (state_q == sic_pkg::SIC_RUN) && i_insn_done && i_op.stop_op
                     && !i_stop_en && !i_break && !i_op.swi_op; // R24
  assign brk_enter = !i_pin_rst && i_break && !in_break_q
                     && (((state_q == sic_pkg::SIC_RUN) && i_insn_done)
                         || (state_q == sic_pkg::SIC_WAIT)); // R14 R19
  assign swi_enter = !i_pin_rst && (state_q == sic_pkg::SIC_RUN) && i_insn_done
                     && i_op.swi_op && !brk_enter; // R12
  assign brk_exit  = in_break_q && (state_q == sic_pkg::SIC_RUN) && i_insn_done
                     && i_op.rti_op;
  assign cnt_clr   = (state_q == sic_pkg::SIC_STOP) || (state_d == sic_pkg::SIC_STOP); // R3
  assign enter_int = (state_d == sic_pkg::SIC_INT) && (state_q != sic_pkg::SIC_INT);

  // Sequencer next state; resets win over every interrupt path
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      sic_pkg::SIC_RUN: begin
        if (i_pin_rst) begin
          state_d = sic_pkg::SIC_RUN; // R13
        end else if (i_insn_done) begin
          if (brk_enter || swi_enter) begin
            state_d = sic_pkg::SIC_INT; // R12 R14
          end else if (i_op.wait_op) begin
            state_d = sic_pkg::SIC_WAIT; // R17 R18
          end else if (i_op.stop_op && i_stop_en) begin
            state_d = sic_pkg::SIC_STOP; // R17 R21
          end else if (hw_ok && !i_op.stop_op) begin
            state_d = sic_pkg::SIC_INT; // R9 R10
          end
        end
      end
      sic_pkg::SIC_WAIT: begin
        if (i_pin_rst) begin
          state_d = sic_pkg::SIC_RUN; // R19
        end else if (brk_enter || hw_any) begin
          state_d = sic_pkg::SIC_INT; // R18 R19
        end
      end
      sic_pkg::SIC_STOP: begin
        if (i_pin_rst || hw_any) begin
          state_d = sic_pkg::SIC_RECOV; // R21
        end
      end
      sic_pkg::SIC_RECOV: begin
        if (rec_done) begin
          state_d = (rst_wake_q || i_pin_rst) ? sic_pkg::SIC_RUN : sic_pkg::SIC_INT; // R21 R25
        end
      end
      sic_pkg::SIC_INT: begin
        state_d = i_pin_rst ? sic_pkg::SIC_RUN : sic_pkg::SIC_INT;
        if (!i_pin_rst) begin
          state_d = sic_pkg::SIC_RUN;
        end
      end
      default: state_d = sic_pkg::SIC_RUN;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= sic_pkg::SIC_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Recovery length and wake cause captured as stop ends
  always_ff @(posedge i_clk) begin // R4
    if (!i_rst_n) begin
      short_stop_recovery_q    <= 1'b0;
      rst_wake_q <= 1'b0;
    end else if ((state_q == sic_pkg::SIC_STOP) && (state_d == sic_pkg::SIC_RECOV)) begin
      short_stop_recovery_q    <= i_short_stop_recovery;
      rst_wake_q <= i_pin_rst;
    end else if ((state_q == sic_pkg::SIC_RECOV) && i_pin_rst) begin
      rst_wake_q <= 1'b1;
    end
  end

  // Interrupt latch and arbitration result
  always_ff @(posedge i_clk) begin // R7 R8
    if (!i_rst_n) begin
      mask_q    <= 1'b0;
      lat_vld_q <= 1'b0;
      vec_q     <= sic_pkg::VEC_RST;
    end else begin
      mask_q <= i_int_mask;
      if (i_pin_rst && (state_q != sic_pkg::SIC_STOP) && (state_q != sic_pkg::SIC_RECOV)) begin
        lat_vld_q <= 1'b0; // R13
      end else if (!lat_vld_q && (brk_enter || swi_enter)) begin
        lat_vld_q <= 1'b1;
        vec_q     <= '{software_interrupt_instr: 1'b1, idx: '0}; // R14
      end else if (!lat_vld_q && hw_any && (state_d != state_q)
                   && (state_d == sic_pkg::SIC_INT || state_d == sic_pkg::SIC_RECOV)) begin
        lat_vld_q <= 1'b1;
        vec_q     <= '{software_interrupt_instr: 1'b0, idx: prio(hw_pend)}; // R10
      end else if (lat_vld_q && (i_vec_done || (mask_q && !i_int_mask))) begin
        lat_vld_q <= 1'b0; // R8
      end
    end
  end

  // Core sequencing pulses
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      int_start_q <= 1'b0;
      stack_pc_q  <= 1'b0;
      set_mask_q  <= 1'b0;
      clr_mask_q  <= 1'b0;
      restore_q   <= 1'b0;
      ilop_q      <= 1'b0;
    end else begin
      int_start_q <= enter_int; // R11 R18 R21
      set_mask_q  <= enter_int; // R11
      if (enter_int) begin
        stack_pc_q <= brk_enter || swi_enter || (lat_vld_q && vec_q.software_interrupt_instr); // R12
      end
      clr_mask_q  <= (state_q == sic_pkg::SIC_RUN)
                     && ((state_d == sic_pkg::SIC_WAIT) || (state_d == sic_pkg::SIC_STOP)); // R17
      restore_q   <= !i_pin_rst && (state_q == sic_pkg::SIC_RUN) && i_insn_done
                     && i_op.rti_op; // R11
      ilop_q      <= ilop; // R24
    end
  end

  // Break state and flag protection
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      in_break_q <= 1'b0;
      allow_q    <= 1'b1;
    end else begin
      if (brk_enter) begin
        in_break_q <= 1'b1; // R14
      end else if (brk_exit || i_pin_rst) begin
        in_break_q <= 1'b0;
      end
      allow_q <= i_break_clear_flag_enable
                 || !(brk_enter || (in_break_q && !brk_exit && !i_pin_rst)); // R15 R16
    end
  end

  // Break wait flag: set beats the software clear
  always_ff @(posedge i_clk) begin // R23
    if (!i_rst_n) begin
      bw_q <= 1'b0;
    end else if (brk_enter && (state_q == sic_pkg::SIC_WAIT)) begin
      bw_q <= 1'b1; // R19
    end else if (i_pin_rst) begin
      bw_q <= 1'b0;
    end else if (i_bw_wr && !i_bw_wdata) begin
      bw_q <= 1'b0;
    end
  end

  // Clock gates, break module and watchdog enables
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      clk_en_q     <= sic_pkg::CLK_EN_RST;
      brk_mod_en_q <= 1'b1;
      wdog_en_q    <= 1'b0;
      wdog_tick_q  <= 1'b0;
      recov_q      <= 1'b0;
    end else begin
      clk_en_q     <= gates(state_d); // R18 R21 R25
      brk_mod_en_q <= (state_d != sic_pkg::SIC_STOP) && (state_d != sic_pkg::SIC_RECOV); // R22
      wdog_en_q    <= !i_watchdog_disable && (state_d != sic_pkg::SIC_STOP); // R20
      wdog_tick_q  <= cnt_ovf && !i_watchdog_disable; // R2
      recov_q      <= state_d == sic_pkg::SIC_RECOV;
    end
  end

  assign o_int_start       = int_start_q;
  assign o_stack_pc        = stack_pc_q;
  assign o_set_mask        = set_mask_q;
  assign o_clr_mask        = clr_mask_q;
  assign o_restore         = restore_q;
  assign o_ilop_rst        = ilop_q;
  assign o_vec             = vec_q;
  assign o_vec_vld         = lat_vld_q;
  assign o_clk_en          = clk_en_q;
  assign o_brk_mod_en      = brk_mod_en_q;
  assign o_in_break        = in_break_q;
  assign o_flag_clr_allow  = allow_q;
  assign o_break_wait_flag = bw_q;
  assign o_wdog_en         = wdog_en_q;
  assign o_wdog_tick       = wdog_tick_q;
  assign o_recov_busy      = recov_q;

endmodule
`default_nettype wire

// ---- sic_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module sic_sva (
  input wire logic                 i_clk,
  input wire logic                 i_rst_n,
  input wire logic                 i_pin_rst,
  input wire logic                 i_stop_en,
  input wire logic                 i_short_stop_recovery,
  input wire logic                 i_break,
  input wire logic                 i_insn_done,
  input wire sic_pkg::sic_op_t     i_op,
  input wire logic                 i_int_mask,
  input wire logic                 i_vec_done,
  input wire logic [7:0]           i_irq_req,
  input wire logic [7:0]           i_irq_en,
  input wire logic                 o_int_start,
  input wire logic                 o_stack_pc,
  input wire logic                 o_set_mask,
  input wire logic                 o_clr_mask,
  input wire logic                 o_ilop_rst,
  input wire sic_pkg::sic_vec_t    o_vec,
  input wire logic                 o_vec_vld,
  input wire sic_pkg::sic_clk_en_t o_clk_en,
  input wire logic                 o_brk_mod_en,
  input wire logic                 o_in_break,
  input wire logic                 o_wdog_en,
  input wire logic                 o_recov_busy
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [12:0] len_q;
  logic        short_q;
  logic        pin_q;
  wire logic   idle = o_clk_en == 4'hF && !o_vec_vld && !o_in_break && !i_break && !i_pin_rst;
  // Length of the current recovery and the recovery select seen at wake
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !o_recov_busy) begin
      len_q   <= 13'h0000;
      pin_q   <= 1'b0;
      short_q <= i_short_stop_recovery;
    end else begin
      len_q <= len_q + 13'h0001;
      pin_q <= pin_q | i_pin_rst;
    end
  end
  start_mask_a: assert property (o_int_start |-> o_set_mask ##1 !o_int_start)
    else $error("stacking without mask set");
  vec_hold_a: assert property (o_vec_vld && $past(o_vec_vld) && !$past(i_vec_done) |->
    $stable(o_vec)) else $error("latched vector changed");
  hw_take_a: assert property (i_insn_done && i_op == 4'h0 && !i_int_mask &&
    (|(i_irq_req & i_irq_en)) && idle |=> o_vec_vld && !o_vec.software_interrupt_instr && o_int_start && !o_stack_pc)
    else $error("hardware interrupt not taken");
  wait_entry_a: assert property (i_insn_done && i_op == 4'h8 && idle |=>
    o_clr_mask && o_clk_en == 4'h7) else $error("wait entry wrong");
  wait_wake_a: assert property (o_clk_en == 4'h7 && (|(i_irq_req & i_irq_en)) && !i_break &&
    !i_pin_rst |=> o_vec_vld && o_int_start) else $error("wait wake late");
  stop_entry_a: assert property (i_insn_done && i_op == 4'h4 && i_stop_en && idle |=>
    o_clk_en == 4'h0 && o_clr_mask && !o_brk_mod_en && !o_wdog_en) else $error("stop entry wrong");
  ilop_a: assert property (i_insn_done && i_op == 4'h4 && !i_stop_en && idle |=>
    o_ilop_rst && o_clk_en == 4'hF) else $error("disabled stop not refused");
  recov_len_a: assert property ($fell(o_recov_busy) && $past(i_rst_n) && !pin_q |->
    len_q == (short_q ? 13'h0020 : 13'h1000)) else $error("recovery length wrong");
  recov_clk_a: assert property ($fell(o_recov_busy) && $past(i_rst_n) |->
    o_clk_en == 4'hF) else $error("clocks not back after recovery");
endmodule
bind sic_top sic_sva chk_u (.*);
`default_nettype wire

// ---- sic_core_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module sic_core_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_go,
  input  wire logic [3:0]  i_cmd,
  input  wire logic        i_slow,
  input  wire logic        i_int_start,
  input  wire logic        i_set_mask,
  input  wire logic        i_clr_mask,
  input  wire logic        i_restore,
  output logic             o_insn_done,
  output sic_pkg::sic_op_t o_op,
  output logic             o_int_mask,
  output logic             o_vec_done
);
  logic [2:0] dly_q;
  // Opcode lines toggle while not qualified by the boundary strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_insn_done <= 1'b0;
      o_op        <= 4'h5;
    end else begin
      o_insn_done <= i_go;
      o_op        <= i_go ? i_cmd : ~o_op;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_set_mask) begin
      o_int_mask <= 1'b1;
    end else if (i_clr_mask || i_restore) begin
      o_int_mask <= 1'b0;
    end
  end
  // Vector fetch one or four cycles after stacking starts
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      dly_q <= 3'h0;
    end else if (i_int_start) begin
      dly_q <= i_slow ? 3'h4 : 3'h1;
    end else if (dly_q != 3'h0) begin
      dly_q <= dly_q - 3'h1;
    end
  end
  assign o_vec_done = (dly_q == 3'h1);
endmodule
`default_nettype wire

// ---- sic_top_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module sic_top_test;
  logic i_clk, i_rst_n, i_pin_rst, i_stop_en, i_short_stop_recovery, i_watchdog_disable;
  logic i_break_clear_flag_enable, i_break, i_insn_done, i_int_mask, i_vec_done, i_bw_wr;
  logic i_bw_wdata, o_int_start, o_stack_pc, o_set_mask, o_clr_mask, o_restore, o_ilop_rst;
  logic o_vec_vld, o_brk_mod_en, o_in_break, o_flag_clr_allow, o_break_wait_flag, o_wdog_en;
  logic o_wdog_tick, o_recov_busy, go, slow;
  logic [3:0] cmd;
  logic [7:0] i_irq_req, i_irq_en;
  sic_pkg::sic_op_t     i_op;
  sic_pkg::sic_vec_t    o_vec;
  sic_pkg::sic_clk_en_t o_clk_en;
  int miscompares, tests_run, cyc, n;
  sic_top dut_u (.*);
  sic_core_model core_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_go(go), .i_cmd(cmd),
    .i_slow(slow), .i_int_start(o_int_start), .i_set_mask(o_set_mask), .i_clr_mask(o_clr_mask),
    .i_restore(o_restore), .o_insn_done(i_insn_done), .o_op(i_op), .o_int_mask(i_int_mask),
    .o_vec_done(i_vec_done));
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic test_done();
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic note(input bit bad, input string w);
    tests_run++;
    if (bad) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, w);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e, input string w);
    note(g !== e, w);
  endtask
  task automatic chk_nib(input logic [3:0] g, input logic [3:0] e, input string w);
    note(g !== e, w);
  endtask
  task automatic chk_cnt(input int g, input int e, input string w);
    note(g != e, w);
  endtask
  task automatic issue(input logic [3:0] op);
    @(posedge i_clk);
    go  <= 1'b1;
    cmd <= op;
    @(posedge i_clk);
    go  <= 1'b0;
  endtask
  task automatic exp_int(input logic [3:0] v, input logic sp, input string w);
    int k;
    k = 0;
    while (o_int_start !== 1'b1 && k < 5000) begin
      @(posedge i_clk);
      k++;
    end
    chk_bit(o_int_start, 1'b1, w);
    chk_nib(o_vec, v, w);
    chk_bit(o_stack_pc, sp, w);
  endtask
  task automatic recov(output int c);
    int k;
    k = 0;
    c = 0;
    while (o_recov_busy !== 1'b1 && k < 20) begin
      @(posedge i_clk);
      k++;
    end
    while (o_recov_busy === 1'b1 && c < 5000) begin
      @(posedge i_clk);
      c++;
    end
  endtask
  initial begin
    {i_clk, i_rst_n, i_pin_rst, i_short_stop_recovery, i_watchdog_disable, go, slow} = 7'h00;
    {i_break_clear_flag_enable, i_break, i_bw_wr, i_bw_wdata, i_irq_req} = 12'h000;
    {i_stop_en, i_irq_en, cmd} = 13'h1FF0;
    cyc         = 0;
    miscompares = 0;
    tests_run   = 0;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    @(posedge i_clk);
    chk_nib(o_clk_en, 4'hF, "clocks after reset");
    chk_bit(o_brk_mod_en & o_flag_clr_allow & ~o_vec_vld & ~o_break_wait_flag, 1'b1, "reset");
    issue(4'h1);
    repeat (3) @(posedge i_clk);
    chk_bit(i_int_mask, 1'b0, "return did not restore");
    slow      <= 1'b1;
    i_irq_req <= 8'h28;
    issue(4'h0);
    exp_int(4'h3, 1'b0, "priority take");
    i_irq_req <= 8'h29;
    @(posedge i_clk);
    @(posedge i_clk);
    chk_nib(o_vec, 4'h3, "latched vector replaced");
    repeat (6) @(posedge i_clk);
    issue(4'h0);
    repeat (4) @(posedge i_clk);
    chk_bit(o_vec_vld, 1'b0, "masked request taken");
    slow      <= 1'b0;
    issue(4'h1);
    repeat (3) @(posedge i_clk);
    issue(4'h0);
    exp_int(4'h0, 1'b0, "pending after return");
    i_irq_req <= 8'h00;
    issue(4'h2);
    exp_int(4'h8, 1'b1, "software interrupt");
    $display("test interrupts done");
    issue(4'h8);
    repeat (2) @(posedge i_clk);
    chk_nib(o_clk_en, 4'h7, "wait clocks");
    chk_bit(o_wdog_en, 1'b1, "watchdog in wait");
    i_irq_req <= 8'h04;
    exp_int(4'h2, 1'b0, "wait wake");
    i_irq_req <= 8'h00;
    issue(4'h8);
    repeat (2) @(posedge i_clk);
    i_break <= 1'b1;
    exp_int(4'h8, 1'b1, "break in wait");
    i_break <= 1'b0;
    @(posedge i_clk);
    chk_bit(o_break_wait_flag & o_in_break, 1'b1, "break wait flag");
    chk_bit(o_flag_clr_allow, 1'b0, "flags unprotected");
    i_bw_wr <= 1'b1;
    @(posedge i_clk);
    i_bw_wr <= 1'b0;
    @(posedge i_clk);
    chk_bit(o_break_wait_flag, 1'b0, "flag write");
    i_break_clear_flag_enable <= 1'b1;
    @(posedge i_clk);
    @(posedge i_clk);
    chk_bit(o_flag_clr_allow, 1'b1, "clear enable ignored");
    i_break_clear_flag_enable <= 1'b0;
    issue(4'h1);
    repeat (2) @(posedge i_clk);
    chk_bit(o_in_break | ~o_flag_clr_allow, 1'b0, "break exit");
    $display("test wait and break done");
    i_short_stop_recovery <= 1'b1;
    issue(4'h4);
    repeat (2) @(posedge i_clk);
    chk_nib(o_clk_en, 4'h0, "stop clocks");
    chk_bit(o_brk_mod_en, 1'b0, "break module in stop");
    i_break <= 1'b1;
    @(posedge i_clk);
    i_break   <= 1'b0;
    i_irq_req <= 8'h10;
    recov(n);
    chk_cnt(n, 32, "short recovery");
    exp_int(4'h4, 1'b0, "stop wake");
    chk_nib(o_clk_en, 4'hF, "clocks back");
    chk_bit(o_in_break, 1'b0, "break taken in stop");
    i_irq_req             <= 8'h00;
    i_short_stop_recovery <= 1'b0;
    issue(4'h4);
    repeat (3) @(posedge i_clk);
    i_pin_rst <= 1'b1;
    @(posedge i_clk);
    i_pin_rst <= 1'b0;
    recov(n);
    chk_cnt(n, 4096, "long recovery");
    chk_bit(o_vec_vld, 1'b0, "pin wake latched");
    i_stop_en <= 1'b0;
    issue(4'h4);
    repeat (2) @(posedge i_clk);
    chk_bit(o_ilop_rst, 1'b1, "disabled stop");
    i_stop_en <= 1'b1;
    $display("test stop done");
    slow      <= 1'b1;
    i_irq_req <= 8'h01;
    issue(4'h0);
    exp_int(4'h0, 1'b0, "take before pin reset");
    i_pin_rst <= 1'b1;
    @(posedge i_clk);
    i_pin_rst <= 1'b0;
    i_irq_req <= 8'h00;
    @(posedge i_clk);
    chk_bit(o_vec_vld, 1'b0, "pin reset kept latch");
    n = 0;
    while (o_wdog_tick !== 1'b1 && n < 5000) begin
      @(posedge i_clk);
      n++;
    end
    repeat (1000) @(posedge i_clk);
    i_pin_rst <= 1'b1;
    @(posedge i_clk);
    i_pin_rst <= 1'b0;
    n = 1001;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wdog_tick !== 1'b1 && n < 5000);
    chk_cnt(n, 4096, "watchdog tick spacing");
    i_watchdog_disable <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk_bit(o_wdog_en, 1'b0, "watchdog not disabled");
    $display("test counter done");
    test_done();
  end
endmodule
`default_nettype wire
